/* rtl/mbdt_top.v */
// Memory bus debug trace: debug address, cycle valid, attributes, fault inject
`timescale 1ns/100ps
`include "mbdt_defines.vh"
module mbdt_top #(
    parameter DW = `MBDT_DATA_W,
    parameter PW = `MBDT_PAR_W,
    parameter AW = `MBDT_ATTR_W
) (
    input wire sys_clk,
    input wire rst_n,
    input wire clkEn,
    input wire dbgEnable,
    input wire memActive,
    input wire colPhase,
    input wire romPhase,
    input wire [1:0] memTarget,
    input wire [1:0] busWidth,
    input wire [31:0] physAddr,
    input wire [AW-1:0] memSource,
    input wire pciActive,
    input wire [AW-1:0] pciSource,
    input wire [1:0] injSel,
    input wire [DW-1:0] injMask,
    input wire [DW-1:0] injValue,
    input wire [PW-1:0] injParMask,
    input wire [PW-1:0] injParValue,
    input wire [DW-1:0] periphData,
    input wire [PW-1:0] periphPar,
    input wire [DW-1:0] memData,
    input wire [PW-1:0] memPar,
    input wire eccError,
    input wire snapClear,
    output reg [`MBDT_DBG_W-1:0] dbgAddr,
    output reg memory_cycle_valid_n,
    output reg [AW-1:0] memAttr,
    output reg [AW-1:0] pciAttr,
    output reg [DW-1:0] periphDataOut,
    output reg [PW-1:0] periphParOut,
    output reg [DW-1:0] memDataOut,
    output reg [PW-1:0] memParOut,
    output reg [DW-1:0] snapData,
    output reg [PW-1:0] snapPar,
    output reg snapValid
);
    reg rstSync1_r;
    reg rstSync2_r;
    wire rstN;
    wire [DW+PW-1:0] snapRd;
    wire snapHeld;
    reg [29:0] unitAddr;
    reg [`MBDT_DBG_W-1:0] dbgAddr_nxt;
    reg cycleValidN_nxt;
    reg [AW-1:0] memAttr_nxt;
    reg [AW-1:0] pciAttr_nxt;
    reg [DW-1:0] periphDataOut_nxt;
    reg [PW-1:0] periphParOut_nxt;
    reg [DW-1:0] memDataOut_nxt;
    reg [PW-1:0] memParOut_nxt;
    wire dramTarget;
    wire romTarget;

    // Row/column targets versus ROM address targets
    assign dramTarget = (memTarget == `MBDT_TGT_DRAM) || (memTarget == `MBDT_TGT_SDRAM);
    assign romTarget = (memTarget == `MBDT_TGT_ROM) || (memTarget == `MBDT_TGT_EXPANSION_PORT_DEVICE);

    // Stuck-at overlay: masked bits forced to value
    function [DW-1:0] force_bits;
        input [DW-1:0] src;
        input [DW-1:0] msk;
        input [DW-1:0] val;
        begin
            force_bits = (src & ~msk) | (val & msk);
        end
    endfunction

    // Same overlay on the parity lanes
    function [PW-1:0] force_par;
        input [PW-1:0] src;
        input [PW-1:0] msk;
        input [PW-1:0] val;
        begin
            force_par = (src & ~msk) | (val & msk);
        end
    endfunction

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstN = rstSync2_r;

    // Address in units of the bus width
    always @*
    begin
        case (busWidth)
            `MBDT_WID_64: unitAddr = {3'h0, physAddr[29:3]};
            `MBDT_WID_32: unitAddr = {2'h0, physAddr[29:2]};
            `MBDT_WID_8: unitAddr = physAddr[29:0];
            default: unitAddr = physAddr[29:0];
        endcase
    end

    // Upper address bits not carried by row/column or ROM address
    always @*
    begin
        dbgAddr_nxt = dbgAddr;
        if (!dbgEnable)
            dbgAddr_nxt = `MBDT_DBG_IDLE;
        else if (memActive && colPhase && dramTarget)
            dbgAddr_nxt = unitAddr[29:14];
        else if (memActive && romPhase && romTarget)
            dbgAddr_nxt = unitAddr[23:8];
    end

    // Cycle valid and attribute values for the next edge
    always @*
    begin
        cycleValidN_nxt = ~memActive;
        memAttr_nxt = {AW{1'b0}};
        pciAttr_nxt = {AW{1'b0}};
        if (memActive)
            memAttr_nxt = memSource;
        if (pciActive)
            pciAttr_nxt = pciSource;
    end

    // Peripheral path with optional stuck-at overlay
    always @*
    begin
        periphDataOut_nxt = periphData;
        periphParOut_nxt = periphPar;
        if (injSel == `MBDT_INJ_PERIPH)
        begin
            periphDataOut_nxt = force_bits(periphData, injMask, injValue);
            periphParOut_nxt = force_par(periphPar, injParMask, injParValue);
        end
    end

    // Memory path with optional stuck-at overlay
    always @*
    begin
        memDataOut_nxt = memData;
        memParOut_nxt = memPar;
        if (injSel == `MBDT_INJ_MEM)
        begin
            memDataOut_nxt = force_bits(memData, injMask, injValue);
            memParOut_nxt = force_par(memPar, injParMask, injParValue);
        end
    end

    always @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            memory_cycle_valid_n <= 1'b1;
            memAttr <= {AW{1'b0}};
            pciAttr <= {AW{1'b0}};
            periphDataOut <= {DW{1'b0}};
            periphParOut <= {PW{1'b0}};
            memDataOut <= {DW{1'b0}};
            memParOut <= {PW{1'b0}};
        end
        else if (clkEn)
        begin
            memory_cycle_valid_n <= cycleValidN_nxt;
            memAttr <= memAttr_nxt;
            pciAttr <= pciAttr_nxt;
            periphDataOut <= periphDataOut_nxt;
            periphParOut <= periphParOut_nxt;
            memDataOut <= memDataOut_nxt;
            memParOut <= memParOut_nxt;
        end
    end

    // Debug address register
    always @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            dbgAddr <= `MBDT_DBG_IDLE;
        else if (clkEn)
            dbgAddr <= dbgAddr_nxt;
    end

    // Snapshot outputs, one stage after the store read
    always @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            snapData <= {DW{1'b0}};
            snapPar <= {PW{1'b0}};
            snapValid <= 1'b0;
        end
        else if (clkEn)
        begin
            snapData <= snapRd[DW+PW-1:PW];
            snapPar <= snapRd[PW-1:0];
            snapValid <= snapHeld;
        end
    end

    // Snapshot of data as checked, faults included
    mbdt_snap_mem #(
        .DW(DW + PW)
    ) uSnap (
        .sysClk(sys_clk),
        .rstN(rstN),
        .clkEn(clkEn),
        .capture(eccError),
        .clear(snapClear),
        .capData({memDataOut, memParOut}),
        .rdData(snapRd),
        .held(snapHeld)
    );
endmodule

/* rtl/mbdt_defines.vh */
// Constants for the memory bus debug trace block
`ifndef MBDT_DEFINES_VH
`define MBDT_DEFINES_VH
`define MBDT_DBG_W 16
`define MBDT_ROMA_W 8
`define MBDT_PHYS_W 30
`define MBDT_DATA_W 64
`define MBDT_PAR_W 8
`define MBDT_ATTR_W 3
`define MBDT_DBG_IDLE 16'h0000
`define MBDT_WID_8 2'h0
`define MBDT_WID_32 2'h1
`define MBDT_WID_64 2'h2
`define MBDT_TGT_DRAM 2'h0
`define MBDT_TGT_SDRAM 2'h1
`define MBDT_TGT_ROM 2'h2
`define MBDT_TGT_EXPANSION_PORT_DEVICE 2'h3
`define MBDT_INJ_NONE 2'h0
`define MBDT_INJ_PERIPH 2'h1
`define MBDT_INJ_MEM 2'h2
`endif

/* rtl/mbdt_snap_mem.v */
// Error snapshot storage with registered read data
`timescale 1ns/100ps
`include "mbdt_defines.vh"
module mbdt_snap_mem #(
    parameter DW = 72
) (
    input wire sysClk,
    input wire rstN,
    input wire clkEn,
    input wire capture,
    input wire clear,
    input wire [DW-1:0] capData,
    output reg [DW-1:0] rdData,
    output reg held
)
;
    reg [DW-1:0] store_r;
    always @(posedge sysClk or negedge rstN)
    begin
        if (!rstN)
        begin
            store_r <= {DW{1'b0}};
            rdData <= {DW{1'b0}};
            held <= 1'b0;
        end
        else if (clkEn)
        begin
            // Capture beats clear; first error is kept
            if (capture && (!held || clear))
            begin
                store_r <= capData;
                held <= 1'b1;
            end
            else if (clear)
                held <= 1'b0;
            rdData <= store_r;
        end
    end
endmodule

/* dv/mbdt_properties.sv */
// Checker of the debug trace outputs
`timescale 1ns/100ps
module mbdt_properties (
    input wire sys_clk,
    input wire rst_n,
    input wire clkEn,
    input wire dbgEnable,
    input wire memActive,
    input wire colPhase,
    input wire romPhase,
    input wire pciActive,
    input wire eccError,
    input wire snapClear,
    input wire memory_cycle_valid_n,
    input wire snapValid,
    input wire [1:0] memTarget,
    input wire [1:0] busWidth,
    input wire [1:0] injSel,
    input wire [2:0] memSource,
    input wire [2:0] pciSource,
    input wire [2:0] memAttr,
    input wire [2:0] pciAttr,
    input wire [15:0] dbgAddr,
    input wire [31:0] physAddr,
    input wire [63:0] injMask,
    input wire [63:0] injValue,
    input wire [63:0] memData,
    input wire [63:0] memDataOut,
    input wire [63:0] snapData
);
    reg [1:0] rstSync_r;
    wire [29:0] unitA = physAddr[29:0] >> (busWidth == 2'h2 ? 3 : busWidth == 2'h1 ? 2 : 0);
    wire [63:0] injX = memData & ~injMask | injValue & injMask;
    // Mirrors the internal reset release
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstSync_r[1]);
    sequence snapSeq;
        ##1 snapValid ##1 snapData == $past(memDataOut, 3);
    endsequence
    cycle_valid_a: assert property (clkEn |=> memory_cycle_valid_n == !$past(memActive))
        else $error("cycle valid");
    dbg_idle_a: assert property (clkEn && !dbgEnable |=> dbgAddr == 16'h0000)
        else $error("debug idle");
    dram_addr_a: assert property (clkEn && dbgEnable && memActive
        && colPhase && !memTarget[1]
        |=> dbgAddr == $past(unitA[29:14])) else $error("dram address");
    rom_addr_a: assert property (clkEn && dbgEnable && memActive
        && romPhase && memTarget[1]
        |=> dbgAddr == $past(unitA[23:8])) else $error("rom address");
    mem_attr_a: assert property (clkEn
        |=> memAttr == ($past(memActive) ? $past(memSource) : 3'h0)) else $error("memory attribute");
    pci_attr_a: assert property (clkEn
        |=> pciAttr == ($past(pciActive) ? $past(pciSource) : 3'h0)) else $error("pci attribute");
    mem_inject_a: assert property (clkEn && injSel == 2'h2 |=> memDataOut == $past(injX))
        else $error("memory inject");
    snap_take_a: assert property (clkEn && $past(clkEn) && eccError && !$past(eccError)
        && !snapValid |=> snapSeq) else $error("snapshot take");
    snap_hold_a: assert property (clkEn && snapValid && $past(snapValid)
        && !$past(snapClear) && !$past(snapClear, 2)
        |=> snapValid && $stable(snapData)) else $error("snapshot hold");
endmodule
bind mbdt_top mbdt_properties chk (.*);

/* dv/mbdt_mem_model.sv */
// Memory device model driving the data path
`timescale 1ns/100ps
module mbdt_mem_model (
    input wire sys_clk,
    input wire memActive,
    input wire [31:0] physAddr,
    output reg [63:0] memData = 64'h0,
    output reg [7:0] memPar = 8'h0
);
    // Idle bus toggles so no stale value survives
    always @(posedge sys_clk)
        if (memActive)
            {memData, memPar} <= {physAddr, ~physAddr, physAddr[7:0]};
        else
            {memData, memPar} <= ~{memData, memPar};
endmodule

/* dv/memory_bus_debug_trace_bench.sv */
// Self-checking bench of the debug trace block
`timescale 1ns/100ps
module memory_bus_debug_trace_bench;
    reg sys_clk = 0, rst_n = 0, clkEn = 1, dbgEnable = 0, memActive = 0, colPhase = 0;
    reg romPhase = 0, pciActive = 0, eccError = 0, snapClear = 0;
    reg [1:0] memTarget = 0, busWidth = 0, injSel = 0;
    reg [2:0] memSource = 0, pciSource = 0;
    reg [31:0] physAddr = 0, a;
    reg [63:0] injMask = 0, injValue = 0, periphData = 0;
    reg [7:0] injParMask = 0, injParValue = 0, periphPar = 0;
    wire [63:0] memData, memDataOut, periphDataOut, snapData;
    wire [7:0] memPar, memParOut, periphParOut, snapPar;
    wire [15:0] dbgAddr;
    wire [2:0] memAttr, pciAttr;
    wire memory_cycle_valid_n, snapValid;
    integer err_count = 0, comparisons = 0, cyc = 0, i;
    reg [29:0] u;
    mbdt_top uut (.*);
    mbdt_mem_model mem (.*);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 2000)
        begin
            err_count = err_count + 1;
            print_verdict;
        end
    end
    task chk(input [63:0] g, input [63:0] e);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    task t_dbg;
        for (i = 0; i < 16; i = i + 1)
        begin
            a = 32'h2ACE_5B79 + i * 32'h0351_1357;
            @(posedge sys_clk);
            dbgEnable <= 1'b1;
            memActive <= 1'b1;
            busWidth <= i[1:0];
            memTarget <= i[3:2];
            colPhase <= i < 8;
            romPhase <= i >= 8;
            physAddr <= a;
            memSource <= i[2:0];
            pciActive <= i[0];
            pciSource <= i[3:1];
            @(posedge sys_clk);
            u = a[29:0] >> (i[1:0] == 2'h2 ? 3 : i[1:0] == 2'h1 ? 2 : 0);
            #1 chk(64'(dbgAddr), 64'(i < 8 ? u[29:14] : u[23:8]));
            chk(64'(memory_cycle_valid_n), 64'h0);
            chk(64'(memAttr), 64'(i[2:0]));
            chk(64'(pciAttr), i[0] ? 64'(i[3:1]) : 64'h0);
        end
        $display("test debug address done");
    endtask
    task t_inj;
        @(posedge sys_clk);
        dbgEnable <= 1'b0;
        memActive <= 1'b0;
        injSel <= 2'h1;
        injMask <= 64'h00FF_F00F_0000_FFFF;
        injValue <= 64'hA5A5_5A5A_C3C3_3C3C;
        periphData <= 64'h0123_4567_89AB_CDEF;
        injParMask <= 8'h0F;
        injParValue <= 8'h96;
        periphPar <= 8'h33;
        @(posedge sys_clk);
        #1 chk(periphDataOut, 64'h01A5_556A_89AB_3C3C);
        chk(64'(periphParOut), 64'h36);
        chk(64'(dbgAddr), 64'h0);
        chk(64'(memory_cycle_valid_n), 64'h1);
        chk(64'(memAttr), 64'h0);
        $display("test inject done");
    endtask
    task t_snap;
        @(posedge sys_clk);
        injSel <= 2'h2;
        injMask <= '1;
        injParMask <= '1;
        injValue <= 64'h0123_4567_89AB_CDEF;
        injParValue <= 8'h5A;
        @(posedge sys_clk);
        eccError <= 1'b1;
        injValue <= 64'hFEDC_BA98_7654_3210;
        repeat (4) @(posedge sys_clk);
        #1 chk(snapData, 64'h0123_4567_89AB_CDEF);
        chk(64'(snapPar), 64'h5A);
        chk(memDataOut, 64'hFEDC_BA98_7654_3210);
        chk(64'(memParOut), 64'h5A);
        @(posedge sys_clk);
        eccError <= 1'b0;
        snapClear <= 1'b1;
        @(posedge sys_clk);
        snapClear <= 1'b0;
        @(posedge sys_clk);
        eccError <= 1'b1;
        #1 chk(64'(snapValid), 64'h0);
        @(posedge sys_clk);
        eccError <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(snapData, 64'hFEDC_BA98_7654_3210);
        $display("test snapshot done");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_dbg;
        t_inj;
        t_snap;
        print_verdict;
    end
endmodule
